// [hdl/mpp_port.sv]
// Purpose: Device end of the single-wire Manchester programming port.
// Assumes: prog_enable_in is the supply comparator above the program level.
// Notes:   Memory side answers mem_rdata in the same cycle as mem_rd_stb.
//
// Overview of operation
// - Program enable releases driver, pin becomes input
// - Supply low again restores magnetic output driver
// - EEPROM write waits 20 ms, then high-low
// - Any bit rate 4 to 100 kbps accepted
// - Mid-bit falling edge one, rising zero
// - Read reply uses the measured command bit period
// - Sync field 00 marks start, measures bit
// - Direction bit zero write, one read
// - Four-bit die select; 0000, 1111 broadcast
// - Field select: whole, bits 11-0, 25-12
// - Address regions: EEPROM, shadow, volatile
// - Data field 32 bits, 26 payload, 6 ECC
// - Access code write carries 32-bit data
// - Read request has no data field
// - Every frame ends with three check bits
// - Four transaction kinds supported
// - Check polynomial x3+x+1, init 111, no sync
// - Data reply only to reads; EEPROM writes get high-low only
// - Address and data sent MSB first

`timescale 1ns/1ps

module mpp_port
  import mpp_pkg::*;
#(
  parameter int EE_WRITE_CYC = EE_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic prog_enable_in,
  input wire logic normal_output,
  input wire logic [1:0] die_addr,
  input wire logic sensor_output_pin_in,
  output logic sensor_output_pin_out,
  output logic sensor_output_pin_oe,
  output logic mem_wr_stb,
  output logic mem_rd_stb,
  output logic [1:0] mem_kind,
  output logic [1:0] mem_region,
  output logic [1:0] mem_field,
  output logic [6:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  output logic prog_mode,
  output logic ee_busy
);

  // ********************************************************************
  // Reset release and input synchronisers
  // ********************************************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] pe_sync;
  logic [2:0] din_sync;
  logic line;
  logic line_prev;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // A level counts only once the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_sync <= 3'h0;
      din_sync <= 3'h0;
      prog_mode <= 1'b0;
      line <= 1'b0;
      line_prev <= 1'b0;
    end else begin
      pe_sync <= {pe_sync[1:0], prog_enable_in};
      din_sync <= {din_sync[1:0], sensor_output_pin_in};
      if (pe_sync[2] == pe_sync[1]) begin
        prog_mode <= pe_sync[2];
      end
      if (din_sync[2] == din_sync[1]) begin
        line <= din_sync[2];
      end
      line_prev <= line;
    end
  end
  assign rise = line & ~line_prev;
  assign fall = ~line & line_prev;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic die_selected(input logic [3:0] cs,
                                        input logic [1:0] id);
    return (cs == CS_NONE) || (cs == CS_ALL) || cs[id];
  endfunction : die_selected
  function automatic logic [1:0] region_of(input logic [6:0] a);
    if (a <= NV_LAST) begin
      return REGION_NV;
    end else if (a <= SHADOW_LAST) begin
      return REGION_SHADOW;
    end
    return REGION_VOL;
  endfunction : region_of
  function automatic logic [2:0] crc_of_word(input logic [31:0] w);
    logic [2:0] c;
    c = CRC_INIT;
    for (int i = DATA_BITS - 1; i >= 0; i--) begin
      c = mpp_crc_step(c, w[i]);
    end
    return c;
  endfunction : crc_of_word

  // ********************************************************************
  // Frame fields, valid in the check state
  // ********************************************************************
  typedef enum {
    S_IDLE, S_SYNC, S_BITS, S_CHECK, S_RDWAIT, S_GAP, S_TX,
    S_EEWAIT, S_ACK_HI, S_ACK_LO
  } mpp_state_t;
  mpp_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] bit_len;
  logic [5:0] bit_cnt;
  logic [FRAME_MAX-1:0] shreg;
  logic [2:0] crc;
  logic [31:0] ee_cnt;
  logic [DATA_BITS+CRC_BITS-1:0] tx_sh;
  logic [5:0] tx_left;
  logic half;
  logic drv_out;
  logic drv_oe;
  logic [1:0] rd_field;
  logic is_read;
  logic [3:0] f_cs;
  logic [1:0] f_fs;
  logic [6:0] f_addr;
  logic [31:0] f_data;
  logic frame_ok;
  logic [CNT_W-1:0] three_q;
  logic [CNT_W-1:0] one_half;
  logic [CNT_W-1:0] half_len;
  logic [31:0] rd_word;

  assign three_q = bit_len - (bit_len >> 2);
  assign one_half = bit_len + (bit_len >> 1);
  assign half_len = bit_len >> 1;
  // Fields sit MSB first behind the direction bit
  always_comb begin
    is_read = (bit_cnt == RD_LEN);
    f_data = shreg[CRC_BITS +: DATA_BITS];
    if (is_read) begin
      f_cs = shreg[15:12];
      f_fs = shreg[11:10];
      f_addr = shreg[9:3];
    end else begin
      f_cs = shreg[47:44];
      f_fs = shreg[43:42];
      f_addr = shreg[41:35];
    end
    frame_ok = (crc == 3'h0)
      && die_selected(f_cs, die_addr)
      && (f_fs != 2'h3)
      && ((is_read && shreg[16])
          || ((bit_cnt == WR_LEN) && !shreg[48]));
  end

  always_comb begin
    case (rd_field)
      FS_LOW: rd_word = mem_rdata & FIELD_LOW_MASK;
      FS_HIGH: rd_word = mem_rdata & FIELD_HIGH_MASK;
      default: rd_word = mem_rdata;
    endcase
  end

  // ********************************************************************
  // Receive, decode, reply and EEPROM completion sequencing
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cnt <= '0;
      bit_len <= '0;
      bit_cnt <= 6'h00;
      shreg <= '0;
      crc <= CRC_INIT;
      ee_cnt <= 32'h00000000;
      tx_sh <= '0;
      tx_left <= 6'h00;
      half <= 1'b0;
      drv_out <= 1'b0;
      drv_oe <= 1'b0;
      rd_field <= FS_WHOLE;
      mem_wr_stb <= 1'b0;
      mem_rd_stb <= 1'b0;
      mem_kind <= KIND_READ;
      mem_region <= REGION_NV;
      mem_field <= FS_WHOLE;
      mem_addr <= 7'h00;
      mem_wdata <= 32'h00000000;
    end else begin
      mem_wr_stb <= 1'b0;
      mem_rd_stb <= 1'b0;
      if (!prog_mode) begin
        // Leaving program mode aborts any frame in flight
        state <= S_IDLE;
        drv_oe <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            // Line rests low; the first rise is mid of sync bit one
            drv_oe <= 1'b0;
            if (rise) begin
              cnt <= '0;
              state <= S_SYNC;
            end
          end
          S_SYNC: begin
            cnt <= cnt + 1'b1;
            if (rise) begin
              if (cnt >= SYNC_LO && cnt <= SYNC_HI) begin
                bit_len <= cnt + 1'b1;
                cnt <= '0;
                bit_cnt <= 6'h00;
                crc <= CRC_INIT;
                state <= S_BITS;
              end else begin
                state <= S_IDLE;
              end
            end else if (cnt > SYNC_HI) begin
              state <= S_IDLE;
            end
          end
          S_BITS: begin
            cnt <= cnt + 1'b1;
            // Edges near a cell boundary are skipped by the window
            if ((rise || fall) && cnt >= three_q) begin
              shreg <= {shreg[FRAME_MAX-2:0], fall};
              crc <= mpp_crc_step(crc, fall);
              if (bit_cnt != 6'h3F) begin
                bit_cnt <= bit_cnt + 1'b1;
              end
              cnt <= '0;
            end else if (cnt > one_half) begin
              state <= S_CHECK;
            end
          end
          S_CHECK: begin
            mem_addr <= f_addr;
            mem_field <= f_fs;
            mem_region <= region_of(f_addr);
            mem_wdata <= f_data;
            rd_field <= f_fs;
            cnt <= '0;
            ee_cnt <= 32'h00000000;
            if (!frame_ok) begin
              state <= S_IDLE;
            end else if (is_read) begin
              mem_kind <= KIND_READ;
              mem_rd_stb <= 1'b1;
              state <= S_RDWAIT;
            end else begin
              mem_wr_stb <= 1'b1;
              if (f_addr == ACCESS_ADDR) begin
                mem_kind <= KIND_ACCESS;
                state <= S_IDLE;
              end else if (region_of(f_addr) == REGION_NV) begin
                mem_kind <= KIND_NV;
                state <= S_EEWAIT;
              end else begin
                mem_kind <= KIND_VOL;
                state <= S_IDLE;
              end
            end
          end
          S_RDWAIT: begin
            tx_sh <= {rd_word, crc_of_word(rd_word)};
            tx_left <= 6'(DATA_BITS + CRC_BITS);
            state <= S_GAP;
          end
          S_GAP: begin
            // Turnaround lets the controller release the line
            cnt <= cnt + 1'b1;
            if (cnt == CNT_W'(bit_len * REPLY_GAP_BITS)) begin
              cnt <= '0;
              half <= 1'b0;
              state <= S_TX;
            end
          end
          S_TX: begin
            drv_oe <= 1'b1;
            drv_out <= tx_sh[DATA_BITS+CRC_BITS-1] ^ half;
            cnt <= cnt + 1'b1;
            if (cnt >= half_len - 1'b1) begin
              cnt <= '0;
              half <= ~half;
              if (half) begin
                tx_sh <= {tx_sh[DATA_BITS+CRC_BITS-2:0], 1'b0};
                tx_left <= tx_left - 1'b1;
                if (tx_left == 6'h01) begin
                  state <= S_IDLE;
                end
              end
            end
          end
          S_EEWAIT: begin
            ee_cnt <= ee_cnt + 1'b1;
            if (ee_cnt >= 32'(EE_WRITE_CYC - 1)) begin
              cnt <= '0;
              state <= S_ACK_HI;
            end
          end
          S_ACK_HI: begin
            // High for one bit so the falling edge is seen
            drv_oe <= 1'b1;
            drv_out <= 1'b1;
            cnt <= cnt + 1'b1;
            if (cnt >= bit_len - 1'b1) begin
              cnt <= '0;
              state <= S_ACK_LO;
            end
          end
          S_ACK_LO: begin
            drv_out <= 1'b0;
            cnt <= cnt + 1'b1;
            if (cnt >= bit_len - 1'b1) begin
              drv_oe <= 1'b0;
              state <= S_IDLE;
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  assign ee_busy = (state == S_EEWAIT);
  // ********************************************************************
  // Pin driver
  // ********************************************************************
  // Open-drain magnetic output outside program mode, push-pull replies in
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sensor_output_pin_out <= 1'b0;
      sensor_output_pin_oe <= 1'b0;
    end else if (prog_mode) begin
      sensor_output_pin_out <= drv_out;
      sensor_output_pin_oe <= drv_oe;
    end else begin
      sensor_output_pin_out <= 1'b0;
      sensor_output_pin_oe <= ~normal_output;
    end
  end

endmodule : mpp_port

// [hdl/mpp_pkg.sv]
// Purpose: Constants and helpers for the Manchester programming port.
// Assumes: 100 MHz core clock, one programming controller on the line.
// Notes:   Every timing count is derived from its printed figure.

package mpp_pkg;

  // ********************************************************************
  // Clock and bit timing
  // ********************************************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int RATE_MIN_BPS = 4_000;
  localparam int RATE_MAX_BPS = 100_000;
  localparam int BIT_CYC_MIN = CLK_HZ / RATE_MAX_BPS;
  localparam int BIT_CYC_MAX = CLK_HZ / RATE_MIN_BPS;
  localparam int CNT_W = 18;
  // Accepted bit period window with slack for controller clock error
  localparam logic [CNT_W-1:0] SYNC_LO = CNT_W'(BIT_CYC_MIN * 3 / 4);
  localparam logic [CNT_W-1:0] SYNC_HI = CNT_W'(BIT_CYC_MAX * 5 / 4);
  localparam int REPLY_GAP_BITS = 2;
  localparam int TW_MS = 20;
  localparam int EE_WRITE_CYCLES = TW_MS * (CLK_HZ / 1000);

  // ********************************************************************
  // Frame layout
  // ********************************************************************
  localparam int HDR_BITS = 14;
  localparam int DATA_BITS = 32;
  localparam int CRC_BITS = 3;
  localparam int FRAME_MAX = HDR_BITS + DATA_BITS + CRC_BITS;
  localparam logic [5:0] RD_LEN = 6'(HDR_BITS + CRC_BITS);
  localparam logic [5:0] WR_LEN = 6'(FRAME_MAX);
  localparam logic [2:0] CRC_INIT = 3'h7;
  localparam logic [3:0] CS_NONE = 4'h0;
  localparam logic [3:0] CS_ALL = 4'hF;
  localparam logic [1:0] FS_WHOLE = 2'h0;
  localparam logic [1:0] FS_LOW = 2'h1;
  localparam logic [1:0] FS_HIGH = 2'h2;
  localparam logic [31:0] FIELD_LOW_MASK = 32'h00000FFF;
  localparam logic [31:0] FIELD_HIGH_MASK = 32'h03FFF000;
  localparam logic [6:0] NV_LAST = 7'h1F;
  localparam logic [6:0] SHADOW_LAST = 7'h3F;
  localparam logic [6:0] ACCESS_ADDR = 7'h79;

  // ********************************************************************
  // Transaction kinds and address regions
  // ********************************************************************
  localparam logic [1:0] KIND_ACCESS = 2'h0;
  localparam logic [1:0] KIND_NV = 2'h1;
  localparam logic [1:0] KIND_VOL = 2'h2;
  localparam logic [1:0] KIND_READ = 2'h3;
  localparam logic [1:0] REGION_NV = 2'h0;
  localparam logic [1:0] REGION_SHADOW = 2'h1;
  localparam logic [1:0] REGION_VOL = 2'h2;

  function automatic logic [2:0] mpp_crc_step(input logic [2:0] c,
                                              input logic b);
    logic fb;
    fb = c[2] ^ b;
    return {c[1], c[0] ^ fb, fb};
  endfunction : mpp_crc_step

endpackage : mpp_pkg

// [bench/mpp_port_properties.sv]
// Purpose: Port checks for the Manchester programming port.
// Assumes: Bound onto mpp_port.
// Notes:   Watches design inputs and outputs.
`timescale 1ns/1ps
module mpp_port_properties
  import mpp_pkg::*;
#(
  parameter int EE_WRITE_CYC = 200
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic prog_enable_in,
  input wire logic normal_output,
  input wire logic [1:0] die_addr,
  input wire logic sensor_output_pin_in,
  input wire logic sensor_output_pin_out,
  input wire logic sensor_output_pin_oe,
  input wire logic mem_wr_stb,
  input wire logic mem_rd_stb,
  input wire logic [1:0] mem_kind,
  input wire logic [1:0] mem_region,
  input wire logic [1:0] mem_field,
  input wire logic [6:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic prog_mode,
  input wire logic ee_busy
);
  // ****************************************
  // Checks
  // ****************************************
  logic stb;
  logic [1:0] exp_region;
  assign stb = mem_wr_stb | mem_rd_stb;
  assign exp_region = (mem_addr <= NV_LAST) ? REGION_NV :
                      (mem_addr <= SHADOW_LAST) ? REGION_SHADOW : REGION_VOL;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence quiet_pin;
    !sensor_output_pin_oe [*8];
  endsequence
  // Long run covers the internal reset release
  sequence normal_run;
    !prog_mode [*6];
  endsequence
  a_mode_entry: assert property ($rose(prog_enable_in) |-> ##[1:8] prog_mode)
    else $error("program mode not entered");
  a_pin_released: assert property ($rose(prog_mode) |-> !sensor_output_pin_oe)
    else $error("pin driven at program entry");
  a_normal_drive: assert property (normal_run |-> !sensor_output_pin_out &&
    sensor_output_pin_oe == !$past(normal_output))
    else $error("normal output not driven");
  a_stb_single: assert property (stb |=> !stb)
    else $error("strobe longer than one cycle");
  a_dir_kind: assert property (stb |-> (mem_kind == KIND_READ) == mem_rd_stb)
    else $error("kind does not match direction");
  a_field_legal: assert property (stb |-> mem_field != 2'h3)
    else $error("unused field accepted");
  a_region_map: assert property (stb && mem_kind != KIND_ACCESS |->
    mem_region == exp_region)
    else $error("region does not match address");
  a_write_silent: assert property (mem_wr_stb |=> quiet_pin)
    else $error("pin driven after write");
  a_read_gap: assert property (mem_rd_stb |=> quiet_pin)
    else $error("reply started without gap");
  a_store_quiet: assert property (ee_busy |-> !sensor_output_pin_oe)
    else $error("pin driven during storage");
  a_store_start: assert property (mem_wr_stb && mem_kind == KIND_NV &&
    mem_addr != ACCESS_ADDR |-> ##[0:3] ee_busy)
    else $error("storage delay not started");
endmodule : mpp_port_properties

// [bench/mpp_ctrl_model.sv]
// Purpose: Programming controller that sends Manchester frames.
// Assumes: Caller hands over payload bits, sync is added here.
// Notes:   Line rests low between frames.
`timescale 1ns/1ps
module mpp_ctrl_model #(
  parameter int BIT_CYC = 1000,
  parameter int START_CYC = 20000
) (
  input wire logic clk,
  output logic drive_en,
  output logic drive_val
);
  // ****************************************
  // Line driver
  // ****************************************
  initial begin
    drive_en = 1'b1;
    drive_val = 1'b0;
  end
  task automatic start_wait();
    repeat (START_CYC) @(negedge clk);
  endtask : start_wait
  task automatic set_drive(input logic en);
    @(negedge clk);
    drive_en = en;
    drive_val = 1'b0;
  endtask : set_drive
  // BIT_CYC sits inside the accepted rate window
  task automatic send_frame(input logic [48:0] bits, input int n);
    logic b;
    drive_val = 1'b0;
    repeat (2 * BIT_CYC) @(negedge clk);
    for (int i = n + 1; i >= 0; i--) begin
      b = (i >= n) ? 1'b0 : bits[i];
      drive_val = b;
      repeat (BIT_CYC / 2) @(negedge clk);
      drive_val = ~b;
      repeat (BIT_CYC / 2) @(negedge clk);
    end
    drive_val = 1'b0;
  endtask : send_frame
endmodule : mpp_ctrl_model

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the Manchester programming port.
// Assumes: Pull-up on the pin, memory side answers with a constant.
// Notes:   Storage delay shortened to keep the run brief.
`timescale 1ns/1ps
module tb_top
  import mpp_pkg::*;
;
  // ****************************************
  // Set-up
  // ****************************************
  localparam int T = 1000;
  localparam int EE_CYC = 200;
  localparam logic [31:0] RDATA = 32'h02F1E5A7;
  logic clk, rstn, prog_enable_in, normal_output;
  logic [1:0] die_addr, mem_kind, mem_region, mem_field;
  logic pin_out, pin_oe, ctl_en, ctl_val, line;
  logic mem_wr_stb, mem_rd_stb, prog_mode, ee_busy;
  logic [6:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  int failures, checked, cycles;
  assign line = pin_oe ? pin_out : (ctl_en ? ctl_val : 1'b1);
  mpp_port #(.EE_WRITE_CYC(EE_CYC)) mpp_port_i (.clk(clk), .rstn(rstn),
    .prog_enable_in(prog_enable_in), .normal_output(normal_output),
    .die_addr(die_addr), .sensor_output_pin_in(line),
    .sensor_output_pin_out(pin_out), .sensor_output_pin_oe(pin_oe),
    .mem_wr_stb(mem_wr_stb), .mem_rd_stb(mem_rd_stb), .mem_kind(mem_kind),
    .mem_region(mem_region), .mem_field(mem_field), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .prog_mode(prog_mode),
    .ee_busy(ee_busy));
  mpp_ctrl_model #(.BIT_CYC(T)) mpp_ctrl_model_i (.clk(clk),
    .drive_en(ctl_en), .drive_val(ctl_val));
  always #5 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : check
  function automatic logic [2:0] crc3(input logic [45:0] v, input int n);
    logic [2:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[2] ^ v[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : crc3
  task automatic wait_stb(output logic wr, output logic rd);
    wr = 1'b0;
    rd = 1'b0;
    for (int i = 0; i < 3 * T && !wr && !rd; i++) begin
      @(negedge clk);
      wr = mem_wr_stb;
      rd = mem_rd_stb;
    end
  endtask : wait_stb
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_entry();
    @(negedge clk);
    prog_enable_in = 1'b1;
    repeat (10) @(negedge clk);
    check("prog_mode", 1, prog_mode);
    check("entry_oe", 0, pin_oe);
    mpp_ctrl_model_i.start_wait();
  endtask : t_entry
  task automatic t_ee_write();
    logic [45:0] p;
    logic wr, rd;
    int n;
    p = {1'b0, CS_ALL, FS_WHOLE, 7'h05, 32'h0123ABCD};
    mpp_ctrl_model_i.send_frame({p, crc3(p, 46)}, 49);
    wait_stb(wr, rd);
    check("wr_stb", 1, wr);
    check("kind", KIND_NV, mem_kind);
    check("region", REGION_NV, mem_region);
    check("addr", 7'h05, mem_addr);
    check("wdata", 32'h0123ABCD, mem_wdata);
    n = 0;
    while (n < EE_CYC + 100 && pin_oe !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    check("store_wait", 1, n >= EE_CYC - 2);
    repeat (T / 2) @(negedge clk);
    check("ack_high", 1, line);
    repeat (T) @(negedge clk);
    check("ack_low", 0, line);
    repeat (T) @(negedge clk);
  endtask : t_ee_write
  task automatic t_read();
    logic [13:0] h;
    logic [34:0] r;
    logic [31:0] d;
    logic wr, rd;
    int g;
    h = {1'b1, 4'b0010, FS_LOW, 7'h45};
    mpp_ctrl_model_i.send_frame(49'({h, crc3(46'(h), 14)}), 17);
    wait_stb(wr, rd);
    mpp_ctrl_model_i.set_drive(1'b0);
    check("rd_stb", 1, rd);
    check("kind", KIND_READ, mem_kind);
    check("region", REGION_VOL, mem_region);
    check("field", FS_LOW, mem_field);
    g = 0;
    while (g < 3 * T && pin_oe !== 1'b1) begin
      @(negedge clk);
      g++;
    end
    check("gap", 1, g >= 2 * T - 5 && g < 3 * T);
    repeat (T / 4) @(negedge clk);
    for (int k = 34; k >= 0; k--) begin
      r[k] = line;
      repeat (T) @(negedge clk);
    end
    d = RDATA & FIELD_LOW_MASK;
    check("reply_data", d, r[34:3]);
    check("reply_crc", crc3(46'(d), 32), r[2:0]);
    check("reply_end", 0, pin_oe);
    mpp_ctrl_model_i.set_drive(1'b1);
  endtask : t_read
  task automatic t_exit();
    @(negedge clk);
    prog_enable_in = 1'b0;
    normal_output = 1'b0;
    repeat (20) @(negedge clk);
    check("exit_oe", 1, pin_oe);
    check("exit_out", 0, pin_out);
  endtask : t_exit
  // ****************************************
  // Run control
  // ****************************************
  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 160000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    prog_enable_in = 1'b0;
    normal_output = 1'b1;
    die_addr = 2'h1;
    mem_rdata = RDATA;
    failures = 0;
    checked = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_entry();
    t_ee_write();
    t_read();
    t_exit();
    print_verdict();
  end
endmodule : tb_top
bind mpp_port mpp_port_properties #(.EE_WRITE_CYC(EE_WRITE_CYC))
  mpp_port_properties_i (.clk(clk), .rstn(rstn),
  .prog_enable_in(prog_enable_in), .normal_output(normal_output),
  .die_addr(die_addr), .sensor_output_pin_in(sensor_output_pin_in),
  .sensor_output_pin_out(sensor_output_pin_out),
  .sensor_output_pin_oe(sensor_output_pin_oe), .mem_wr_stb(mem_wr_stb),
  .mem_rd_stb(mem_rd_stb), .mem_kind(mem_kind), .mem_region(mem_region),
  .mem_field(mem_field), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .prog_mode(prog_mode), .ee_busy(ee_busy));
